// *** core/rcd_defs.svh ***
// Constants for the reference clock output divider.
`ifndef RCD_DEFS_SVH
`define RCD_DEFS_SVH
`define RCD_ADDR_CTRL     2'h0
`define RCD_ADDR_STATUS   2'h1
`define RCD_BIT_ENABLE    7
`define RCD_BIT_PIN_OE    6
`define RCD_BIT_SLEW      5
`define RCD_DUTY_HI       4
`define RCD_DUTY_LO       3
`define RCD_DIV_HI        2
`define RCD_DIV_LO        0
`define RCD_CTRL_RESET    8'h30
`define RCD_INSTR_DIV     2'h3
`endif

// *** core/rcd_pkg.sv ***
// Types shared by the reference clock output divider.
`default_nettype none
package rcd_pkg;
  typedef enum logic [2:0] {
    RCD_PIN_REFCLK = 3'b001,
    RCD_PIN_INSTR  = 3'b010,
    RCD_PIN_OSC    = 3'b100
  } rcd_pin_mode_e;
  typedef struct packed {
    logic       refclk_module_enable;
    logic       refclk_pin_output_enable;
    logic       refclk_slew_limit_enable;
    logic [1:0] refclk_duty_select;
    logic [2:0] refclk_divider_select;
  } rcd_ctrl_s;
  typedef struct packed {
    logic low_power_crystal_mode;
    logic standard_crystal_mode;
    logic high_speed_crystal_mode;
    logic instr_clock_out_config_enable;
  } rcd_cfg_s;
endpackage
`default_nettype wire

// *** core/rcd_top.sv ***
// Reference clock output divider with control register and pin arbitration.
// Functional notes
// [RULE1] The output is derived only from the system clock in every oscillator setup.
// [RULE2] The divider runs only while the module enable bit is set.
// [RULE3] The pin carries the divided clock only with output enable and module enable set.
// [RULE4] A three-bit divider select picks one of eight ratios.
// [RULE5] A two-bit duty select sets the high-time proportion.
// [RULE6] The slew limit control follows its bit, set or cleared.
// [RULE7] Undivided, the source clock passes through unless 0% duty is chosen; the code drives a level that flips on every enabled edge instead.
// [RULE8] At divide-by-two the 25% and 75% choices are approximations.
// [RULE9] Any reset disables the module and restores the control defaults.
// [RULE10] Firmware configures divider, duty and slew before turning on the pin.
// [RULE11] Crystal modes claim the pin as oscillator input and block the output.
// [RULE12] The instruction clock option forces the oscillator clock divided by four.
// [RULE13] Divider code 000 is undivided and each step doubles up to 128.
// [RULE14] Duty codes 11, 10, 01, 00 give 75%, 50%, 25% and 0%.
// [RULE15] While the clock is stopped all outputs hold their levels.
// [RULE16] The wave comes from a cycle counter with duty as a fraction of the period.
//
// Added by the designer: the plain strobed port and the register offsets.
`default_nettype none
`include "rcd_defs.svh"
module rcd_top (
  input  wire logic           i_clk,
  input  wire logic           i_srst,
  input  wire logic           i_ce,
  input  wire logic [1:0]     i_addr,
  input  wire logic [7:0]     i_wdata,
  input  wire logic           i_wr,
  input  wire logic           i_rd,
  input  wire rcd_pkg::rcd_cfg_s i_cfg,
  output logic [7:0]          o_rdata,
  output logic                o_refclk_output_pin,
  output logic                o_refclk_output_pin_oe,
  output logic                o_slew_limit
);
  rcd_pkg::rcd_ctrl_s     ctrl_q;
  rcd_pkg::rcd_pin_mode_e mode;
  logic [1:0]             instr_cnt_q;
  logic                   instr_clk_q;
  logic                   wave;
  logic                   ref_lvl;
  logic                   crystal;
  logic                   pin_d;
  logic                   oe_d;

  // How the block hangs together.
  // The control byte holds the module enable, the pin enable, the slew limit
  // bit, the duty select and the divider select, in that order from the top.
  // A small counter module turns the divider and duty selects into a wave.
  // The undivided setting cannot carry the clock itself through a flip-flop,
  // so it is shown as a level that flips on every enabled edge instead.
  // Pin ownership is decided every cycle: a crystal mode wins, then the
  // instruction clock option, and only then the reference clock.
  // Every output is registered, so the pin lags its inputs by one cycle.
  // The clock enable stands in for the system clock stopping in Sleep: while
  // it is low no flip-flop in this block or in the counter may change.
  // Firmware is expected to program the divider, duty and slew settings
  // before it sets the pin enable; the logic does not enforce that order.

  // Control register; reset restores defaults and disables the module.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ctrl_q <= `RCD_CTRL_RESET; // RULE9
    end else if (i_ce && i_wr && i_addr == `RCD_ADDR_CTRL) begin
      ctrl_q <= i_wdata; // RULE4 RULE5
    end
  end

  // Read data stand one cycle after the read strobe; others read zero.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rdata <= 8'h00;
    end else if (i_ce) begin
      if (i_rd && i_addr == `RCD_ADDR_CTRL) begin
        o_rdata <= ctrl_q;
      end else if (i_rd && i_addr == `RCD_ADDR_STATUS) begin
        o_rdata <= {5'h00, mode};
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end

  // Divided wave generated from system clock cycles only.
  rcd_wave_gen #(.CW(7)) u_wave ( // RULE1 RULE16
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .i_ce   (i_ce),
    .i_run  (ctrl_q.refclk_module_enable), // RULE2
    .i_div  (ctrl_q.refclk_divider_select), // RULE13
    .i_duty (ctrl_q.refclk_duty_select), // RULE14 RULE8
    .o_wave (wave)
  );

  // Undivided mode passes the clock; sampled per cycle it toggles each edge.
  always_comb begin
    if (ctrl_q.refclk_divider_select == 3'h0) begin
      ref_lvl = (ctrl_q.refclk_duty_select != 2'h0) && !o_refclk_output_pin; // RULE7
    end else begin
      ref_lvl = wave;
    end
  end

  // Instruction clock: oscillator divided by four.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      instr_cnt_q <= 2'h0;
      instr_clk_q <= 1'b0;
    end else if (i_ce) begin
      instr_cnt_q <= instr_cnt_q + 2'h1;
      if (instr_cnt_q[0]) begin
        instr_clk_q <= !instr_clk_q; // RULE12
      end
    end
  end

  // Pin ownership: crystal first, then instruction clock, then reference clock.
  assign crystal = i_cfg.low_power_crystal_mode | i_cfg.standard_crystal_mode | i_cfg.high_speed_crystal_mode;
  always_comb begin
    if (crystal) begin
      mode  = rcd_pkg::RCD_PIN_OSC; // RULE11
      pin_d = 1'b0;
      oe_d  = 1'b0;
    end else if (i_cfg.instr_clock_out_config_enable) begin
      mode  = rcd_pkg::RCD_PIN_INSTR; // RULE12
      pin_d = instr_clk_q;
      oe_d  = 1'b1;
    end else begin
      mode  = rcd_pkg::RCD_PIN_REFCLK;
      oe_d  = ctrl_q.refclk_module_enable & ctrl_q.refclk_pin_output_enable; // RULE3 RULE10
      pin_d = oe_d & ref_lvl;
    end
  end

  // Pin and slew outputs freeze while the clock enable is low.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_refclk_output_pin    <= 1'b0;
      o_refclk_output_pin_oe <= 1'b0;
      o_slew_limit           <= 1'b1;
    end else if (i_ce) begin // RULE15
      o_refclk_output_pin    <= pin_d;
      o_refclk_output_pin_oe <= oe_d;
      o_slew_limit           <= ctrl_q.refclk_slew_limit_enable; // RULE6
    end
  end

  // Checks on the pin arbitration and hold behaviour.
  // All of them are synchronous to the system clock and are switched off
  // while reset is held, except the ones that check what reset itself does.
  // Properties that look at the counter reach into the wave generator by
  // its instance name, so a rename there must be carried over here.
  sequence refclk_off_s;
    !ctrl_q.refclk_module_enable && !crystal && !i_cfg.instr_clock_out_config_enable;
  endsequence
  pin_off_dis_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE3
    (i_ce ##0 refclk_off_s) |=> !o_refclk_output_pin_oe)
    else $error("pin driven while module disabled");
  crystal_block_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE11
    i_ce && crystal |=> !o_refclk_output_pin_oe && !o_refclk_output_pin)
    else $error("pin driven in crystal mode");
  hold_frozen_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE15
    !i_ce |=> $stable(o_refclk_output_pin) && $stable(o_slew_limit))
    else $error("outputs changed while frozen");
  slew_follow_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE6
    i_ce |=> o_slew_limit == $past(ctrl_q.refclk_slew_limit_enable))
    else $error("slew output not following control");
  zero_duty_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE14
    i_ce && !crystal && !i_cfg.instr_clock_out_config_enable && ctrl_q.refclk_duty_select == 2'h0
    |=> !o_refclk_output_pin)
    else $error("pin high at zero duty");
  instr_prio_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE12
    i_ce && !crystal && i_cfg.instr_clock_out_config_enable |=> o_refclk_output_pin_oe)
    else $error("instruction clock not driven");
  reset_dflt_a: assert property (@(posedge i_clk) // RULE9
    i_srst |=> ctrl_q == `RCD_CTRL_RESET)
    else $error("control not reset");
  half_duty_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE13
    ctrl_q.refclk_divider_select == 3'h2 && ctrl_q.refclk_duty_select == 2'h2 && ctrl_q.refclk_module_enable
    && i_ce && u_wave.cnt_q[1:0] == 2'h0 |-> wave)
    else $error("divide by four wave wrong");

  // Named steps used by the duty and divider checks below.
  // Each one describes a setting rather than an event, so they are fused
  // with ##0 and never combined with the logical operators.
  // The reference clock owns the pin and is switched through to it.
  sequence drive_s;
    i_ce && !crystal && !i_cfg.instr_clock_out_config_enable
    && ctrl_q.refclk_module_enable && ctrl_q.refclk_pin_output_enable;
  endsequence
  // Undivided setting with a non-zero duty: the pin toggles every cycle.
  sequence undiv_s;
    ctrl_q.refclk_divider_select == 3'h0 && ctrl_q.refclk_duty_select != 2'h0;
  endsequence
  // Divide-by-two with a non-zero duty, at the first cycle of a period.
  sequence div2_start_s;
    ctrl_q.refclk_divider_select == 3'h1 && ctrl_q.refclk_duty_select != 2'h0 && !u_wave.cnt_q[0];
  endsequence
  // Divide-by-four settings, used by the duty fraction checks.
  sequence div4_s;
    ctrl_q.refclk_divider_select == 3'h2;
  endsequence
  // Divide-by-128 at half duty, the longest period.
  sequence div128_s;
    ctrl_q.refclk_divider_select == 3'h7 && ctrl_q.refclk_duty_select == 2'h2;
  endsequence

  // Checks of the divided wave, the register port and the reset values.
  // Pin enable tracks both enable bits one cycle later.
  oe_follow_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE3
    i_ce && !crystal && !i_cfg.instr_clock_out_config_enable
    |=> o_refclk_output_pin_oe == $past(ctrl_q.refclk_module_enable && ctrl_q.refclk_pin_output_enable))
    else $error("pin enable not following control bits");
  // A high pin level is only ever shown while the pin is driven.
  pin_needs_oe_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE3
    o_refclk_output_pin |-> o_refclk_output_pin_oe)
    else $error("pin high while not driven");
  // A disabled module keeps its divider counter parked at zero.
  run_stop_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE2
    i_ce && !ctrl_q.refclk_module_enable |=> u_wave.cnt_q == '0)
    else $error("divider counting while disabled");
  // An enabled module counts one system clock cycle per enabled edge.
  run_count_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE16
    i_ce && ctrl_q.refclk_module_enable |=> u_wave.cnt_q == 7'($past(u_wave.cnt_q) + 7'h01))
    else $error("divider counter skipped a cycle");
  // Undivided, the pin level flips on every enabled edge.
  undiv_toggle_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE7
    drive_s ##0 undiv_s |=> o_refclk_output_pin != $past(o_refclk_output_pin))
    else $error("undivided output not toggling");
  // A zero duty keeps the divided wave low in every setting.
  zero_wave_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE7
    ctrl_q.refclk_duty_select == 2'h0 |-> !wave)
    else $error("wave high at zero duty");
  // Divide-by-two gives one high cycle at the start of each period.
  div2_high_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE8
    drive_s ##0 div2_start_s |=> o_refclk_output_pin)
    else $error("divide by two wave wrong");
  // At 25% only the first of four cycles is high.
  quarter_hi_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE14
    div4_s ##0 (ctrl_q.refclk_duty_select == 2'h1 && u_wave.cnt_q[1:0] == 2'h0) |-> wave)
    else $error("quarter duty high phase wrong");
  quarter_lo_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE14
    div4_s ##0 (ctrl_q.refclk_duty_select == 2'h1 && u_wave.cnt_q[1:0] != 2'h0) |-> !wave)
    else $error("quarter duty low phase wrong");
  // At 75% the last of four cycles is low.
  three_q_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE14
    div4_s ##0 (ctrl_q.refclk_duty_select == 2'h3 && u_wave.cnt_q[1:0] == 2'h3) |-> !wave)
    else $error("three quarter duty low phase wrong");
  // Divide-by-eight at half duty is high for four cycles, then low.
  eighth_hi_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE5
    ctrl_q.refclk_divider_select == 3'h3 && ctrl_q.refclk_duty_select == 2'h2 && u_wave.cnt_q[2:0] == 3'h3 |-> wave)
    else $error("divide by eight high phase wrong");
  eighth_lo_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE5
    ctrl_q.refclk_divider_select == 3'h3 && ctrl_q.refclk_duty_select == 2'h2 && u_wave.cnt_q[2:0] == 3'h4 |-> !wave)
    else $error("divide by eight low phase wrong");
  // Divide-by-128 at half duty switches low exactly half way round.
  slow_hi_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE13
    div128_s ##0 (u_wave.cnt_q == 7'h3f) |-> wave)
    else $error("divide by 128 high phase wrong");
  slow_lo_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE13
    div128_s ##0 (u_wave.cnt_q == 7'h40) |-> !wave)
    else $error("divide by 128 low phase wrong");
  // Writes to the control address land on the next edge.
  ctrl_write_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE4
    i_ce && i_wr && i_addr == `RCD_ADDR_CTRL |=> ctrl_q == $past(i_wdata))
    else $error("control write lost");
  // Writes to reserved addresses leave the control byte alone.
  wr_refuse_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE4
    i_ce && i_wr && i_addr[1] |=> $stable(ctrl_q))
    else $error("reserved write changed control");
  // Reads of the control address return the control byte.
  ctrl_read_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE5
    i_ce && i_rd && i_addr == `RCD_ADDR_CTRL |=> o_rdata == $past(ctrl_q))
    else $error("control read wrong");
  // Reads of reserved addresses return zero.
  rd_refuse_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE4
    i_ce && i_rd && i_addr[1] |=> o_rdata == 8'h00)
    else $error("reserved read not zero");
  // Read data are zero after each enabled cycle without a read.
  rdata_idle_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE4
    i_ce && !i_rd |=> o_rdata == 8'h00)
    else $error("read data not cleared");
  // Reads of the status address return the pin owner code.
  status_read_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE11
    i_ce && i_rd && i_addr == `RCD_ADDR_STATUS |=> o_rdata == {5'h00, $past(mode)})
    else $error("status read wrong");
  // The instruction clock option reports itself as pin owner.
  instr_stat_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE12
    i_ce && i_rd && i_addr == `RCD_ADDR_STATUS && !crystal && i_cfg.instr_clock_out_config_enable |=> o_rdata == 8'h02)
    else $error("instruction clock owner not reported");
  // The instruction clock option puts the free divide-by-four wave on the pin.
  instr_wave_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE12
    i_ce && !crystal && i_cfg.instr_clock_out_config_enable |=> o_refclk_output_pin == $past(instr_clk_q))
    else $error("instruction clock wave wrong");
  // The instruction clock counter runs freely on every enabled edge.
  instr_count_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE12
    i_ce |=> instr_cnt_q == 2'($past(instr_cnt_q) + 2'h1))
    else $error("instruction clock counter stalled");
  // Reset leaves the pin undriven and low with slew limiting on.
  reset_pins_a: assert property (@(posedge i_clk) // RULE9
    i_srst |=> !o_refclk_output_pin_oe && !o_refclk_output_pin && o_slew_limit)
    else $error("pin outputs not reset");
  // A frozen clock enable holds the control byte, counter and pin enable.
  freeze_state_a: assert property (@(posedge i_clk) disable iff (i_srst) // RULE15
    !i_ce |=> $stable(ctrl_q) && $stable(u_wave.cnt_q) && $stable(o_refclk_output_pin_oe))
    else $error("state changed while frozen");
endmodule
`default_nettype wire

// *** core/rcd_wave_gen.sv ***
// Counter that produces a divided clock wave with selectable duty.
`default_nettype none
`include "rcd_defs.svh"
module rcd_wave_gen #(
  parameter int CW = 7
) (
  input  wire logic          i_clk,
  input  wire logic          i_srst,
  input  wire logic          i_ce,
  input  wire logic          i_run,
  input  wire logic [2:0]    i_div,
  input  wire logic [1:0]    i_duty,
  output logic               o_wave
);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] mask;
  logic [CW-1:0] half;
  logic [CW-1:0] quart;
  logic [CW-1:0] phase;
  logic          hi;

  // Period mask and duty thresholds follow the divider select.
  always_comb begin
    mask  = CW'((8'h01 << i_div) - 8'h01);
    phase = cnt_q & mask;
    half  = CW'((8'h01 << i_div) >> 1);
    quart = CW'((8'h01 << i_div) >> 2);
    unique case (i_duty)
      2'h0:    hi = 1'b0;
      2'h1:    hi = (i_div == 3'h1) ? (phase == '0) : (phase < quart);
      2'h2:    hi = phase < half;
      default: hi = (i_div == 3'h1) ? (phase == '0) : (phase < (half + quart));
    endcase
  end

  // Counter of system clock cycles; held in reset while not running.
  always_ff @(posedge i_clk) begin
    if (i_srst || (i_ce && !i_run)) begin
      cnt_q <= '0;
    end else if (i_ce) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  assign o_wave = hi;
endmodule
`default_nettype wire

// *** dv/rcd_ext_dev.sv ***
// Model of an external device clocked from the reference clock pin.
`default_nettype none
module rcd_ext_dev (
  input  wire logic i_clk,
  input  wire logic i_pin,
  input  wire logic i_oe,
  output var  int   o_rises,
  output var  int   o_highs
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_q = 1'b0;
  // Counts rising edges and high cycles seen only while the pin is driven.
  always @(posedge i_clk) begin
    last_q <= i_pin & i_oe;
    if (i_oe && i_pin) o_highs <= o_highs + 1;
    if (i_oe && i_pin && !last_q) o_rises <= o_rises + 1;
  end
endmodule
`default_nettype wire

// *** dv/rcd_tb.sv ***
// Self-checking testbench for the reference clock output divider.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic              i_clk = 1'b0;
  logic              i_srst = 1'b1;
  logic              i_ce = 1'b1;
  logic              i_wr = 1'b0;
  logic              i_rd = 1'b0;
  logic [1:0]        i_addr = 2'h0;
  logic [7:0]        i_wdata = 8'h00;
  rcd_pkg::rcd_cfg_s i_cfg = '0;
  logic [7:0]        rdata;
  logic              pin;
  logic              oe;
  logic              slew;
  int                rises;
  int                highs;
  int                fails = 0;
  int                cmp_count = 0;
  int                cyc = 0;
  rcd_top u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .i_cfg(i_cfg), .o_rdata(rdata), .o_refclk_output_pin(pin), .o_refclk_output_pin_oe(oe),
    .o_slew_limit(slew));
  rcd_ext_dev u_ext (.i_clk(i_clk), .i_pin(pin), .i_oe(oe), .o_rises(rises), .o_highs(highs));
  // Free-running system clock.
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Cuts a hang short.
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    repeat (4) @(posedge i_clk);
    #1;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // Counts pin edges and high cycles over n cycles.
  task automatic meas(input int n, input logic [7:0] er, input logic [7:0] eh);
    int r0;
    int h0;
    #1;
    r0 = rises;
    h0 = highs;
    repeat (n) @(posedge i_clk);
    #1 chk(8'(rises - r0), er);
    chk(8'(highs - h0), eh);
  endtask
  task automatic t_reset;
    rd(2'h0, 8'h30);
    chk({5'h0, pin, oe, slew}, 8'h01);
    rd(2'h2, 8'h00);
  endtask
  task automatic t_wave;
    wr(2'h0, 8'h12);
    wr(2'h0, 8'hd2);
    chk({7'h0, oe}, 8'h01);
    meas(40, 8'd10, 8'd20);
    wr(2'h0, 8'hda);
    meas(40, 8'd10, 8'd30);
    wr(2'h0, 8'hca);
    meas(40, 8'd10, 8'd10);
    wr(2'h0, 8'hd7);
    meas(256, 8'd2, 8'd128);
    wr(2'h0, 8'hd9);
    meas(40, 8'd20, 8'd20);
    wr(2'h0, 8'hd0);
    meas(40, 8'd20, 8'd20);
    wr(2'h0, 8'hc0);
    meas(40, 8'd0, 8'd0);
  endtask
  task automatic t_enable;
    wr(2'h0, 8'h52);
    chk({7'h0, oe}, 8'h00);
    wr(2'h0, 8'h92);
    chk({7'h0, oe}, 8'h00);
    wr(2'h0, 8'h00);
    chk({7'h0, slew}, 8'h00);
    wr(2'h0, 8'h20);
    chk({7'h0, slew}, 8'h01);
  endtask
  task automatic t_owner;
    wr(2'h0, 8'hd3);
    rd(2'h1, 8'h01);
    i_cfg <= 4'h4;
    rd(2'h1, 8'h04);
    chk({7'h0, oe}, 8'h00);
    i_cfg <= 4'h5;
    rd(2'h1, 8'h04);
    i_cfg <= 4'h1;
    rd(2'h1, 8'h02);
    meas(40, 8'd10, 8'd20);
    i_cfg <= 4'h0;
  endtask
  task automatic t_sleep;
    logic p0;
    wr(2'h0, 8'hd2);
    i_ce <= 1'b0;
    @(posedge i_clk);
    #1 p0 = pin;
    repeat (8) begin
      @(posedge i_clk);
      #1 chk({7'h0, pin}, {7'h0, p0});
    end
    i_ce <= 1'b1;
  endtask
  // Main sequence, ending with a reset in mid-run.
  initial begin
    repeat (5) @(posedge i_clk);
    i_srst <= 1'b0;
    t_reset();
    t_wave();
    t_enable();
    t_owner();
    t_sleep();
    wr(2'h0, 8'hd2);
    i_srst <= 1'b1;
    @(posedge i_clk);
    i_srst <= 1'b0;
    t_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
